// file: core/timer_irq_dma_pkg.sv
// constants and types for the timer interrupt and dma control section
// Overview of operation
// - global enable off blocks all timer interrupts
// - dma enable set by software, hardware clears
// - capture0 mask gates capture or end-of-block interrupt
// - compare0 mask gates compare or end-of-block interrupt
// - capture1, compare1, wrap masks gate own interrupts
// - count pointer high bits, bit2 toggles in swap
// - count pointer bit0 selects memory or registers
// - pointer bit1 shows channel, hardware driven
// - address pointer high bits, bit2 toggles in swap
// - register transfers ignore address pointer except swap
// - segment select picks segment register for memory
// - vector top five software, two hardware, bit0 zero
// - group code 00 wrap, 10 capture, 11 compare
// - capture0 block end set in swap, else one
// - compare0 block end set in swap, else one
// - capture source selects capture register or port
// - compare destination selects compare register or port
// - swap enable puts both channels in swap
// - three-bit shared interrupt and dma priority level
// - vector address fits in low 256 locations
// - overrun set when request arrives before clear
// - capture interrupt is or/and of two captures
package timer_irq_dma_pkg;
  localparam logic [7:0] dma_count_pointer_off = 8'hf0;
  localparam logic [7:0] dma_address_pointer_off = 8'hf1;
  localparam logic [7:0] timer_vector_base_off = 8'hf2;
  localparam logic [7:0] irq_dma_control_off = 8'hf3;
  localparam logic [7:0] irq_dma_mask_off = 8'hff;
  localparam logic [7:0] control_reset = 8'hc7;
  localparam logic [7:0] mask_reset = 8'h00;
  localparam logic [7:0] pointer_reset = 8'h00;
  localparam logic [7:0] vector_reset = 8'h00;
  // mask register bits
  localparam int global_irq_enable_bit = 7;
  localparam int capture0_dma_enable_bit = 6;
  localparam int capture0_irq_mask_bit = 5;
  localparam int capture1_irq_mask_bit = 4;
  localparam int compare0_dma_enable_bit = 3;
  localparam int compare0_irq_mask_bit = 2;
  localparam int compare1_irq_mask_bit = 1;
  localparam int wrap_irq_mask_bit = 0;
  // control register bits
  localparam int capture0_block_end_bit = 7;
  localparam int compare0_block_end_bit = 6;
  localparam int capture_dma_source_bit = 5;
  localparam int compare_dma_dest_bit = 4;
  localparam int swap_enable_bit = 3;
  // pointer bits
  localparam int pointer_swap_bit = 2;
  localparam int channel_direction_bit = 1;
  localparam int area_select_bit = 0;
  localparam logic [1:0] group_wrap = 2'h0;
  localparam logic [1:0] group_capture = 2'h2;
  localparam logic [1:0] group_compare = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } reg_wr_t;

  typedef struct packed {
    logic [4:0] vector_high;
    logic [1:0] group;
    logic [2:0] level;
  } irq_req_t;

  typedef struct packed {
    logic channel;
    logic reg_file;
    logic use_dma_segment;
    logic port_io;
    logic [5:0] count_ptr;
    logic [5:0] addr_ptr;
    logic [2:0] level;
  } dma_req_t;
endpackage

// file: core/timer_irq_dma_ctrl.sv
// interrupt and dma control section of the multifunction timer
`timescale 1ns/1ps
module timer_irq_dma_ctrl
  import timer_irq_dma_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire reg_wr_t reg_wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic capture0_evt,
  input wire logic capture1_evt,
  input wire logic compare0_evt,
  input wire logic compare1_evt,
  input wire logic wrap_evt,
  input wire logic capture0_flag_clr,
  input wire logic compare0_flag_clr,
  input wire logic overrun_clr,
  input wire logic capture_irq_combine,
  input wire logic [1:0] capt_pending,
  input wire logic compare1_pending,
  input wire logic wrap_pending,
  input wire logic compare0_pending,
  input wire logic capture0_eob,
  input wire logic compare0_eob,
  output logic irq_valid,
  input wire logic irq_ready,
  output irq_req_t irq_req,
  output logic dma_valid,
  input wire logic dma_ready,
  output dma_req_t dma_req,
  output logic capture0_overrun,
  output logic compare0_overrun
);
  logic [7:0] mask_q;
  logic [7:0] ctrl_q;
  logic [7:0] dcp_q;
  logic [7:0] dap_q;
  logic [4:0] vec_q;
  logic [1:0] group_q;
  logic cp0_flag_q;
  logic cm0_flag_q;
  logic ovr_cp_q;
  logic ovr_cm_q;
  logic wr_mask;
  logic wr_ctrl;
  logic wr_dcp;
  logic wr_dap;
  logic wr_vec;
  logic swap;
  logic cp_dma;
  logic cm_dma;
  logic capt_irq;
  logic [2:0] grp_active;
  logic irq_any;
  logic [1:0] grp_d;
  logic chan_q;
  logic cp_eob_q;
  logic cm_eob_q;
  logic irq_taken;
  // two-entry dma request buffer
  dma_req_t buf_q [2];
  logic [1:0] cnt_q;
  logic rd_ptr_q;
  logic wr_ptr_q;
  logic push;
  logic pop;
  logic push_ready;
  logic [1:0] dma_evt;
  dma_req_t new_req;

  function automatic logic wr_hit(input reg_wr_t w, input logic [7:0] off);
    wr_hit = w.wr && (w.addr == off);
  endfunction

  function automatic logic [7:0] ptr_view(input logic [7:0] p, input logic ch);
    ptr_view = {p[7:2], ch, p[0]};
  endfunction

  assign wr_mask = wr_hit(reg_wr, irq_dma_mask_off);
  assign wr_ctrl = wr_hit(reg_wr, irq_dma_control_off);
  assign wr_dcp = wr_hit(reg_wr, dma_count_pointer_off);
  assign wr_dap = wr_hit(reg_wr, dma_address_pointer_off);
  assign wr_vec = wr_hit(reg_wr, timer_vector_base_off);
  assign swap = ctrl_q[swap_enable_bit];
  assign cp_dma = mask_q[capture0_dma_enable_bit];
  assign cm_dma = mask_q[compare0_dma_enable_bit];

  // mask register; dma enables cleared by hardware at block end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mask_q <= mask_reset;
    end
    else
    begin
      if (wr_mask)
      begin
        mask_q <= reg_wr.wdata;
      end
      if (capture0_eob && cp_dma)
      begin
        mask_q[capture0_dma_enable_bit] <= 1'b0;
      end
      if (compare0_eob && cm_dma)
      begin
        mask_q[compare0_dma_enable_bit] <= 1'b0;
      end
    end
  end

  // control register with block-end flags
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_q <= control_reset;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= reg_wr.wdata;
      end
      if (!(wr_ctrl ? reg_wr.wdata[swap_enable_bit] : swap))
      begin
        ctrl_q[capture0_block_end_bit] <= 1'b1;
        ctrl_q[compare0_block_end_bit] <= 1'b1;
      end
      else
      begin
        if (capture0_eob && cp_dma)
        begin
          ctrl_q[capture0_block_end_bit] <= 1'b1;
        end
        if (compare0_eob && cm_dma)
        begin
          ctrl_q[compare0_block_end_bit] <= 1'b1;
        end
      end
    end
  end

  // pointers; bit1 is hardware-driven, bit2 toggles at compare0 block end in swap
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dcp_q <= pointer_reset;
      dap_q <= pointer_reset;
    end
    else
    begin
      if (wr_dcp)
      begin
        dcp_q <= reg_wr.wdata;
      end
      if (wr_dap)
      begin
        dap_q <= reg_wr.wdata;
      end
      if (swap && compare0_eob && cm_dma)
      begin
        dcp_q[pointer_swap_bit] <= ~(wr_dcp ? reg_wr.wdata[pointer_swap_bit] : dcp_q[pointer_swap_bit]);
        dap_q[pointer_swap_bit] <= ~(wr_dap ? reg_wr.wdata[pointer_swap_bit] : dap_q[pointer_swap_bit]);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      vec_q <= vector_reset[7:3];
    end
    else if (wr_vec)
    begin
      vec_q <= reg_wr.wdata[7:3];
    end
  end

  // overrun: new request while the event flag is still set; set wins
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cp0_flag_q <= 1'b0;
      cm0_flag_q <= 1'b0;
      ovr_cp_q <= 1'b0;
      ovr_cm_q <= 1'b0;
    end
    else
    begin
      cp0_flag_q <= capture0_evt | (cp0_flag_q & ~capture0_flag_clr);
      cm0_flag_q <= compare0_evt | (cm0_flag_q & ~compare0_flag_clr);
      ovr_cp_q <= (capture0_evt & cp0_flag_q) | (ovr_cp_q & ~overrun_clr);
      ovr_cm_q <= (compare0_evt & cm0_flag_q) | (ovr_cm_q & ~overrun_clr);
    end
  end

  // block-end interrupts held until a request of their group is taken
  assign irq_taken = irq_valid & irq_ready;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cp_eob_q <= 1'b0;
      cm_eob_q <= 1'b0;
    end
    else
    begin
      cp_eob_q <= (capture0_eob & cp_dma) | (cp_eob_q & ~(irq_taken && irq_req.group == group_capture));
      cm_eob_q <= (compare0_eob & cm_dma) | (cm_eob_q & ~(irq_taken && irq_req.group == group_compare));
    end
  end

  // group requests; capture group is or/and of two captures
  always_comb
  begin
    if (capture_irq_combine)
    begin
      capt_irq = capt_pending[0] & capt_pending[1];
    end
    else
    begin
      capt_irq = capt_pending[0] | capt_pending[1];
    end
    grp_active[0] = wrap_pending & mask_q[wrap_irq_mask_bit];
    grp_active[1] = (capt_irq & (cp_dma ? 1'b0 : mask_q[capture0_irq_mask_bit]))
      | (cp_eob_q & mask_q[capture0_irq_mask_bit])
      | (capt_pending[1] & ~capture_irq_combine & mask_q[capture1_irq_mask_bit]);
    grp_active[2] = (compare0_pending & ~cm_dma & mask_q[compare0_irq_mask_bit])
      | (cm_eob_q & mask_q[compare0_irq_mask_bit])
      | (compare1_pending & mask_q[compare1_irq_mask_bit]);
    irq_any = mask_q[global_irq_enable_bit] & (|grp_active);
    if (grp_active[2])
    begin
      grp_d = group_compare;
    end
    else if (grp_active[1])
    begin
      grp_d = group_capture;
    end
    else
    begin
      grp_d = group_wrap;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq_valid <= 1'b0;
      group_q <= group_wrap;
      irq_req <= '0;
    end
    else if (!irq_valid || irq_ready)
    begin
      irq_valid <= irq_any;
      group_q <= grp_d;
      irq_req <= '{vector_high: vec_q, group: grp_d, level: ctrl_q[2:0]};
    end
  end

  // dma requests through a two-entry buffer
  assign dma_evt[0] = capture0_evt & cp_dma;
  assign dma_evt[1] = compare0_evt & cm_dma & ~dma_evt[0];
  assign push_ready = (cnt_q != 2'd2);
  assign push = (|dma_evt) & push_ready;
  assign pop = (cnt_q != 2'd0) & dma_ready;

  always_comb
  begin
    new_req.channel = dma_evt[1];
    new_req.reg_file = dcp_q[area_select_bit];
    new_req.use_dma_segment = dap_q[area_select_bit] & ~dcp_q[area_select_bit];
    new_req.port_io = dma_evt[1] ? ctrl_q[compare_dma_dest_bit] : ctrl_q[capture_dma_source_bit];
    new_req.count_ptr = dcp_q[7:2];
    // register transfers keep only the table-select bit of the address pointer
    new_req.addr_ptr = dcp_q[area_select_bit] ? {3'h0, swap & dap_q[pointer_swap_bit], 2'h0} : dap_q[7:2];
    new_req.level = ctrl_q[2:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q <= 2'd0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop)
      begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      buf_q[wr_ptr_q] <= new_req;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dma_valid <= 1'b0;
      dma_req <= '0;
    end
    else
    begin
      dma_valid <= (cnt_q + {1'b0, push} - {1'b0, pop}) != 2'd0;
      dma_req <= (cnt_q == 2'd0 || (cnt_q == 2'd1 && pop)) ? new_req
        : buf_q[pop ? ~rd_ptr_q : rd_ptr_q];
    end
  end

  // channel of the last transfer taken, shown in bit1 of both pointers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      chan_q <= 1'b0;
    end
    else if (dma_valid && dma_ready)
    begin
      chan_q <= dma_req.channel;
    end
  end

  // overrun outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      capture0_overrun <= 1'b0;
      compare0_overrun <= 1'b0;
    end
    else
    begin
      capture0_overrun <= ovr_cp_q;
      compare0_overrun <= ovr_cm_q;
    end
  end

  // register readback
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_data <= 8'h00;
    end
    else
    begin
      unique case (rd_addr)
        dma_count_pointer_off: rd_data <= ptr_view(dcp_q, chan_q);
        dma_address_pointer_off: rd_data <= ptr_view(dap_q, chan_q);
        timer_vector_base_off: rd_data <= {vec_q, group_q, 1'b0};
        irq_dma_control_off: rd_data <= ctrl_q;
        irq_dma_mask_off: rd_data <= mask_q;
        default: rd_data <= 8'h00;
      endcase
    end
  end
endmodule // timer_irq_dma_ctrl

// file: tb/timer_irq_dma_chk.sv
// assertion checker for the timer interrupt and dma control section
`timescale 1ns/1ps
module timer_irq_dma_chk
  import timer_irq_dma_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire reg_wr_t reg_wr,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic capture0_evt,
  input wire logic capture0_eob,
  input wire logic irq_valid,
  input wire logic irq_ready,
  input wire irq_req_t irq_req,
  input wire logic dma_valid,
  input wire logic dma_ready,
  input wire dma_req_t dma_req
);
  logic [7:0] msk_q;
  logic [7:0] ctl_q;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      msk_q <= 8'h00;
      ctl_q <= 8'hc7;
    end
    else
    begin
      if (reg_wr.wr && reg_wr.addr == 8'hff)
        msk_q <= reg_wr.wdata;
      if (capture0_eob)
        msk_q[6] <= 1'b0;
      if (reg_wr.wr && reg_wr.addr == 8'hf3)
        ctl_q <= reg_wr.wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence irq_stall_s;
    irq_valid && !irq_ready;
  endsequence
  sequence dma_stall_s;
    dma_valid && !dma_ready;
  endsequence
  chk_global_gate: assert property ($rose(irq_valid) |-> msk_q[7] || $past(msk_q[7]))
    else $error("irq with global enable off");
  chk_group_code: assert property (irq_valid |-> irq_req.group != 2'h1)
    else $error("reserved group code");
  chk_irq_level: assert property ($rose(irq_valid) |-> irq_req.level == ctl_q[2:0])
    else $error("irq level wrong");
  chk_irq_hold: assert property (irq_stall_s |=> irq_valid && $stable(irq_req))
    else $error("irq request dropped");
  chk_dma_hold: assert property (dma_stall_s |=> dma_valid && $stable(dma_req))
    else $error("dma request dropped");
  chk_dma_start: assert property (capture0_evt && msk_q[6] && !dma_valid |=>
    dma_valid && dma_req.channel == 1'b0 && dma_req.level == ctl_q[2:0])
    else $error("dma request missing");
  chk_eob_forced: assert property (rd_addr == 8'hf3 && !ctl_q[3] && $stable(ctl_q) |=>
    rd_data[7:6] == 2'b11)
    else $error("block end flags not forced");
  chk_vector_bit: assert property (rd_addr == 8'hf2 |=> rd_data[0] == 1'b0)
    else $error("vector bit0 set");
endmodule // timer_irq_dma_chk
bind timer_irq_dma_ctrl timer_irq_dma_chk timer_irq_dma_chk_i (
  .clk, .srst, .reg_wr, .rd_addr, .rd_data, .capture0_evt, .capture0_eob,
  .irq_valid, .irq_ready, .irq_req, .dma_valid, .dma_ready, .dma_req
);

// file: tb/cpu_arb_model.sv
// interrupt and dma arbiter model facing the control section
`timescale 1ns/1ps
module cpu_arb_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic irq_valid,
  input wire logic dma_valid,
  input wire logic dma_chan,
  output logic irq_ready,
  output logic dma_ready,
  output logic eob_cp,
  output logic eob_cm,
  output int n_dma
);
  assign irq_ready = !slow;
  assign dma_ready = !slow;
  always_ff @(posedge clk)
  begin
    if (srst)
      n_dma <= 0;
    else if (dma_valid && dma_ready)
      n_dma <= n_dma + 1;
  end
  // every second transfer ends a block on the channel that made it
  always_ff @(posedge clk)
  begin
    eob_cp <= !srst && dma_valid && dma_ready && n_dma[0] && !dma_chan;
    eob_cm <= !srst && dma_valid && dma_ready && n_dma[0] && dma_chan;
  end
endmodule // cpu_arb_model

// file: tb/testbench.sv
// self-checking bench for the timer interrupt and dma control section
`timescale 1ns/1ps
module testbench;
  import timer_irq_dma_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic slow = 1'b0;
  reg_wr_t reg_wr = '0;
  logic [7:0] rd_addr = 8'h00;
  logic [4:0] ev = '0;
  logic [2:0] clr = '0;
  logic comb = 1'b0;
  logic [1:0] capt = 2'h0;
  logic [2:0] pend = 3'h0;
  logic [7:0] rd_data;
  logic irq_valid, irq_ready, dma_valid, dma_ready, eob_cp, eob_cm, c0_ovr, m0_ovr;
  irq_req_t irq_req;
  dma_req_t dma_req;
  dma_req_t seen_req;
  logic [7:0] head;
  int n_dma;
  int err_count = 0;
  int cmp_count = 0;
  logic [1:0] grp;
  logic [15:0] tbl [9] = '{16'h820b, 16'h0209, 16'h8104, 16'h8005, 16'ha022,
    16'hb0a1, 16'hb0e2, 16'h8413, 16'h9042};
  initial forever #2.5 clk = ~clk;
  timer_irq_dma_ctrl timer_irq_dma_ctrl_i (
    .clk, .srst, .reg_wr, .rd_addr, .rd_data, .capture0_evt(ev[0]), .capture1_evt(ev[1]),
    .compare0_evt(ev[2]), .compare1_evt(ev[3]), .wrap_evt(ev[4]), .capture0_flag_clr(clr[0]),
    .compare0_flag_clr(clr[1]), .overrun_clr(clr[2]), .capture_irq_combine(comb),
    .capt_pending(capt), .compare1_pending(pend[1]), .wrap_pending(pend[0]),
    .compare0_pending(pend[2]), .capture0_eob(eob_cp), .compare0_eob(eob_cm), .irq_valid, .irq_ready,
    .irq_req, .dma_valid, .dma_ready, .dma_req, .capture0_overrun(c0_ovr), .compare0_overrun(m0_ovr)
  );
  cpu_arb_model cpu_arb_model_i (
    .clk, .srst, .slow, .irq_valid, .dma_valid, .dma_chan(dma_req.channel), .irq_ready, .dma_ready,
    .eob_cp, .eob_cm, .n_dma
  );
  // last request taken by the arbiter
  always @(posedge clk)
  begin
    if (dma_valid && dma_ready)
    begin
      seen_req <= dma_req;
    end
  end
  assign head = {4'h0, seen_req.channel, seen_req.reg_file, seen_req.use_dma_segment, seen_req.port_io};
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) reg_wr <= '{a, d, 1'b1};
    @(posedge clk) reg_wr <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    @(posedge clk) rd_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk("register", rd_data & m, exp);
  endtask
  task automatic wait_irq(output logic [1:0] g);
    g = 2'h1;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk);
      #1 if (irq_valid === 1'b1)
      begin
        g = irq_req.group;
        break;
      end
    end
  endtask
  task automatic dma_pair(input int ch, input int total);
    @(posedge clk)
    begin
      slow <= 1'b1;
      ev[ch] <= 1'b1;
    end
    @(posedge clk) ev[ch] <= 1'b0;
    @(posedge clk) ev[ch] <= 1'b1;
    @(posedge clk)
    begin
      ev[ch] <= 1'b0;
      slow <= 1'b0;
    end
    for (int i = 0; i < 20 && n_dma < total; i++)
      @(posedge clk);
    if (n_dma != total)
    begin
      err_count++;
      finish_test;
    end
    repeat (2) @(posedge clk);
    chk("dma count", n_dma[7:0], total[7:0]);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(8'hf3, 8'hc7);
    rd(8'hff, 8'h00);
    wr(8'hf0, 8'hab);
    rd(8'hf0, 8'ha9);
    wr(8'hf1, 8'h57);
    rd(8'hf1, 8'h55);
    wr(8'hf2, 8'hff);
    rd(8'hf2, 8'hf8, 8'hf9);
    wr(8'h10, 8'h5a);
    rd(8'h10, 8'h00);
    $display("test registers done");
    wr(8'hf3, 8'h05);
    foreach (tbl[k])
    begin
      wr(8'hff, tbl[k][15:8]);
      @(posedge clk)
      begin
        slow <= (k == 0);
        comb <= tbl[k][7];
        capt <= tbl[k][6:5];
        pend <= tbl[k][4:2];
      end
      wait_irq(grp);
      @(posedge clk)
      begin
        slow <= 1'b0;
        capt <= 2'h0;
        pend <= 3'h0;
      end
      chk("group", {6'h0, grp}, {6'h0, tbl[k][1:0]});
      repeat (3) @(posedge clk);
    end
    $display("test interrupts done");
    wr(8'hf3, 8'h0d);
    wr(8'hff, 8'h40);
    dma_pair(0, 2);
    chk("dma head", head, 8'h04);
    rd(8'hff, 8'h00);
    rd(8'hf3, 8'h8d);
    wr(8'hff, 8'h08);
    dma_pair(2, 4);
    chk("dma head", head, 8'h0c);
    chk("dma count ptr", {2'h0, seen_req.count_ptr}, 8'h2a);
    chk("dma addr ptr", {2'h0, seen_req.addr_ptr}, 8'h04);
    chk("dma level", {5'h0, seen_req.level}, 8'h05);
    chk("compare overrun", {7'h0, m0_ovr}, 8'h01);
    rd(8'hff, 8'h00);
    rd(8'hf3, 8'hcd);
    rd(8'hf0, 8'haf);
    rd(8'hf1, 8'h53);
    @(posedge clk) clr <= 3'h5;
    @(posedge clk) clr <= 3'h0;
    @(posedge clk) ev[0] <= 1'b1;
    @(posedge clk) ev[0] <= 1'b0;
    @(posedge clk) #1 chk("overrun", {7'h0, c0_ovr}, 8'h00);
    @(posedge clk) ev[0] <= 1'b1;
    @(posedge clk) ev[0] <= 1'b0;
    @(posedge clk) #1 chk("overrun", {7'h0, c0_ovr}, 8'h01);
    @(posedge clk) clr[2] <= 1'b1;
    @(posedge clk) clr[2] <= 1'b0;
    @(posedge clk) #1 chk("overrun", {7'h0, c0_ovr}, 8'h00);
    $display("test dma done");
    finish_test;
  end
endmodule // testbench
